// ===== ofs_defines.vh
// Purpose: constants for the output function select block
// Assumes: 16-bit parameter port, offsets are the parameter indices
// Notes:   none
// Overview of operation
// - code 1: output left free for other use
// - code 2: ready, switched on or enabled
// - code 3: operation enabled only
// - code 4: relative move after capture active/finished
// - code 5: position deviation inside window
// - code 6: velocity deviation inside window
// - code 7: motor velocity below threshold
// - code 8: motor current below threshold
// - code 9: halt request acknowledged
// - code 13: motor at standstill
// - code 14: selected class 1-4 error active
// - code 16: selected class 0 warning active
// - code 22: motor turning positive
// - code 23: motor turning negative
// - writes accepted only with power stage disabled
// - new value persists, active after power-on
`ifndef OFS_DEFINES_VH
`define OFS_DEFINES_VH
`define OFS_ADDR_OUT3      16'h0718
`define OFS_ADDR_OUT4      16'h071a
`define OFS_RESET_SEL      16'h0001
`define OFS_FN_FREE        16'h0001
`define OFS_FN_NOFAULT     16'h0002
`define OFS_FN_ACTIVE      16'h0003
`define OFS_FN_RELATIVE_MOVE_AFTER_CAPTURE        16'h0004
`define OFS_FN_POSWIN      16'h0005
`define OFS_FN_VELWIN      16'h0006
`define OFS_FN_VELBELOW    16'h0007
`define OFS_FN_CURBELOW    16'h0008
`define OFS_FN_HALTACK     16'h0009
`define OFS_FN_STANDSTILL  16'h000d
`define OFS_FN_SELERR      16'h000e
`define OFS_FN_SELWARN     16'h0010
`define OFS_FN_MOVEPOS     16'h0016
`define OFS_FN_MOVENEG     16'h0017
`endif

// ===== ofs_load_model.sv
// Purpose: load wired to outputs three and four
// Assumes: load samples on the drive clock
// Notes: lags one cycle, like a remote input stage
module ofs_load_model (
  input  wire        clk,
  input  wire        outThree,
  input  wire        outFour,
  output logic [1:0] seen
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge clk) seen <= {outFour, outThree};
endmodule

// ===== ofs_output_function_select.v
// Purpose: routes drive status conditions to outputs three and four
// Assumes: single-cycle parameter write/read strobes, synchronous inputs
// Notes:   persistent copy lives in a reg here; arst_n resets it to code 1 like the active copy
`include "ofs_defines.vh"
module ofs_output_function_select (
  input  wire        ref_clk,
  input  wire        arst_n,
  input  wire        powerOnLoad,
  input  wire        paramWrite,
  input  wire        paramRead,
  input  wire [15:0] paramAddr,
  input  wire [15:0] paramWdata,
  output reg  [15:0] paramRdata,
  output reg         paramAck,
  output reg         paramReject,
  input  wire        powerStageEnabled,
  input  wire        stReadyToSwitchOn,
  input  wire        stSwitchedOn,
  input  wire        stOperationEnabled,
  input  wire        relativeMoveAfterCapture,
  input  wire        posInWindow,
  input  wire        velInWindow,
  input  wire        velBelowThreshold,
  input  wire        curBelowThreshold,
  input  wire        haltAck,
  input  wire        motorStandstill,
  input  wire        selectedError,
  input  wire        selectedWarning,
  input  wire        movePositive,
  input  wire        moveNegative,
  input  wire        freeOut3,
  input  wire        freeOut4,
  output reg         digitalOutputThree,
  output reg         digitalOutputFour
);

  //////////////////////////////////////////////////////////////////////////////
  reg        rstMeta;
  reg        rstSync;
  reg [15:0] storedSel3;
  reg [15:0] storedSel4;
  reg [15:0] activeSel3;
  reg [15:0] activeSel4;
  wire       hitAddr;
  wire       codeOk;

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  function isDefined;
    input [15:0] code;
    begin
      case (code)
        `OFS_FN_FREE, `OFS_FN_NOFAULT, `OFS_FN_ACTIVE, `OFS_FN_RELATIVE_MOVE_AFTER_CAPTURE,
        `OFS_FN_POSWIN, `OFS_FN_VELWIN, `OFS_FN_VELBELOW, `OFS_FN_CURBELOW,
        `OFS_FN_HALTACK, `OFS_FN_STANDSTILL, `OFS_FN_SELERR, `OFS_FN_SELWARN,
        `OFS_FN_MOVEPOS, `OFS_FN_MOVENEG: isDefined = 1'b1;
        default: isDefined = 1'b0;
      endcase
    end
  endfunction

  // one condition slot per defined code, in code order; slot 0 is free use
  localparam NSLOT = 14;
  localparam NOUT  = 2;

  // one-hot slot of a selector code; all zero for a code that is not defined
  function [NSLOT-1:0] slotOf;
    input [15:0] code;
    begin
      slotOf = {NSLOT{1'b0}};
      case (code)
        `OFS_FN_FREE:       slotOf[0]  = 1'b1;
        `OFS_FN_NOFAULT:    slotOf[1]  = 1'b1;
        `OFS_FN_ACTIVE:     slotOf[2]  = 1'b1;
        `OFS_FN_RELATIVE_MOVE_AFTER_CAPTURE:       slotOf[3]  = 1'b1;
        `OFS_FN_POSWIN:     slotOf[4]  = 1'b1;
        `OFS_FN_VELWIN:     slotOf[5]  = 1'b1;
        `OFS_FN_VELBELOW:   slotOf[6]  = 1'b1;
        `OFS_FN_CURBELOW:   slotOf[7]  = 1'b1;
        `OFS_FN_HALTACK:    slotOf[8]  = 1'b1;
        `OFS_FN_STANDSTILL: slotOf[9]  = 1'b1;
        `OFS_FN_SELERR:     slotOf[10] = 1'b1;
        `OFS_FN_SELWARN:    slotOf[11] = 1'b1;
        `OFS_FN_MOVEPOS:    slotOf[12] = 1'b1;
        `OFS_FN_MOVENEG:    slotOf[13] = 1'b1;
        default:            slotOf     = {NSLOT{1'b0}};
      endcase
    end
  endfunction

  assign hitAddr = (paramAddr == `OFS_ADDR_OUT3) || (paramAddr == `OFS_ADDR_OUT4);
  assign codeOk  = isDefined(paramWdata);

  //////////////////////////////////////////////////////////////////////////////
  // request decode: a write is taken only when every guard passes, so a
  // refused write leaves both stored copies untouched
  wire       hitOut3;
  wire       hitOut4;
  wire       writeTaken;
  wire       writeRefused;
  wire       readTaken;
  wire       readRefused;
  wire       writeOut3;
  wire       writeOut4;

  assign hitOut3      = (paramAddr == `OFS_ADDR_OUT3);
  assign hitOut4      = (paramAddr == `OFS_ADDR_OUT4);
  assign writeTaken   = paramWrite && hitAddr && !powerStageEnabled && codeOk;
  assign writeRefused = paramWrite && !writeTaken;
  // write and read in one cycle: the write wins and the read is dropped
  assign readTaken    = paramRead && !paramWrite && hitAddr;
  assign readRefused  = paramRead && !paramWrite && !hitAddr;
  assign writeOut3    = writeTaken && hitOut3;
  assign writeOut4    = writeTaken && hitOut4;

  //////////////////////////////////////////////////////////////////////////////
  // stored selectors: what a read returns and what the next power-on uses
  always @(posedge ref_clk or negedge rstSync) begin
    if (!rstSync) begin
      storedSel3 <= `OFS_RESET_SEL;
    end else if (writeOut3) begin
      storedSel3 <= paramWdata;
    end
  end

  always @(posedge ref_clk or negedge rstSync) begin
    if (!rstSync) begin
      storedSel4 <= `OFS_RESET_SEL;
    end else if (writeOut4) begin
      storedSel4 <= paramWdata;
    end
  end

  // active copy follows only on a power-on load, so a new selection never
  // switches an output while the drive is running
  always @(posedge ref_clk or negedge rstSync) begin
    if (!rstSync) begin
      activeSel3 <= `OFS_RESET_SEL;
      activeSel4 <= `OFS_RESET_SEL;
    end else if (powerOnLoad) begin
      activeSel3 <= storedSel3;
      activeSel4 <= storedSel4;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // answer pulses last exactly one cycle
  always @(posedge ref_clk or negedge rstSync) begin
    if (!rstSync) begin
      paramAck    <= 1'b0;
      paramReject <= 1'b0;
    end else begin
      paramAck    <= writeTaken || readTaken;
      paramReject <= writeRefused || readRefused;
    end
  end

  // read data holds until the next read request
  always @(posedge ref_clk or negedge rstSync) begin
    if (!rstSync) begin
      paramRdata <= 16'h0000;
    end else if (readTaken) begin
      paramRdata <= hitOut3 ? storedSel3 : storedSel4;
    end else if (readRefused) begin
      paramRdata <= 16'h0000;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // shared condition lines; slot 0 is filled per output with its free level
  wire [NSLOT-1:0] condShared;
  wire [NOUT-1:0]  freeLevel;
  wire [NOUT-1:0]  routed;
  wire [15:0]      activeView [0:NOUT-1];

  assign condShared[0]  = 1'b0;
  assign condShared[1]  = stReadyToSwitchOn | stSwitchedOn | stOperationEnabled;
  assign condShared[2]  = stOperationEnabled;
  assign condShared[3]  = relativeMoveAfterCapture;
  assign condShared[4]  = posInWindow;
  assign condShared[5]  = velInWindow;
  assign condShared[6]  = velBelowThreshold;
  assign condShared[7]  = curBelowThreshold;
  assign condShared[8]  = haltAck;
  assign condShared[9]  = motorStandstill;
  assign condShared[10] = selectedError;
  assign condShared[11] = selectedWarning;
  assign condShared[12] = movePositive;
  assign condShared[13] = moveNegative;

  assign freeLevel[0]  = freeOut3;
  assign freeLevel[1]  = freeOut4;
  assign activeView[0] = activeSel3;
  assign activeView[1] = activeSel4;

  // an undefined code cannot be stored, but would give a low output anyway
  genvar ch;
  generate
    for (ch = 0; ch < NOUT; ch = ch + 1) begin : gen_chan
      wire [NSLOT-1:0] pick;
      wire [NSLOT-1:0] cond;
      assign pick       = slotOf(activeView[ch]);
      assign cond       = condShared | {{(NSLOT-1){1'b0}}, freeLevel[ch]};
      assign routed[ch] = |(pick & cond);
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk or negedge rstSync) begin
    if (!rstSync) begin
      digitalOutputThree <= 1'b0;
      digitalOutputFour  <= 1'b0;
    end else begin
      digitalOutputThree <= routed[0];
      digitalOutputFour  <= routed[1];
    end
  end

endmodule

// ===== ofs_output_function_select_checker.sv
// Purpose: parameter port handshake checks
// Assumes: no request until reset is released
// Notes: output routing is judged by the bench
module ofs_output_function_select_checker (
  input wire        ref_clk,
  input wire        arst_n,
  input wire        paramWrite,
  input wire        paramRead,
  input wire [15:0] paramAddr,
  input wire [15:0] paramWdata,
  input wire [15:0] paramRdata,
  input wire        paramAck,
  input wire        paramReject,
  input wire        powerStageEnabled
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  wire map = paramAddr == 16'h0718 || paramAddr == 16'h071a;
  wire ok = paramWdata inside {[16'h1:16'h9], 16'hd, 16'he, 16'h10, 16'h16, 16'h17};
  sequence s_rd; paramRead && !paramWrite; endsequence
  sequence s_wr; paramWrite && !powerStageEnabled && map && ok; endsequence
  property p_stg; paramWrite && powerStageEnabled |=> paramReject; endproperty
  a_stg: assert property (p_stg) else $error("stage on write");
  property p_cod; paramWrite && !ok |=> paramReject; endproperty
  a_cod: assert property (p_cod) else $error("bad code taken");
  property p_acc; s_wr |=> paramAck; endproperty
  a_acc: assert property (p_acc) else $error("good write refused");
  property p_one; paramWrite || paramRead |=> paramAck != paramReject; endproperty
  a_one: assert property (p_one) else $error("answer count");
  property p_idl; !paramWrite && !paramRead |=> !paramAck && !paramReject; endproperty
  a_idl: assert property (p_idl) else $error("answer without request");
  property p_hld; !(paramRead && !paramWrite) |=> $stable(paramRdata); endproperty
  a_hld: assert property (p_hld) else $error("read data moved");
  property p_rdb; s_rd ##0 !map |=> paramReject && paramRdata == 16'h0; endproperty
  a_rdb: assert property (p_rdb) else $error("unmapped read");
  property p_rdg; s_rd ##0 map |=> paramAck; endproperty
  a_rdg: assert property (p_rdg) else $error("read refused");
endmodule
bind ofs_output_function_select ofs_output_function_select_checker u_chk (.*);

// ===== ofs_output_function_select_tb.sv
// Purpose: random and corner stimulus for the selectors
// Assumes: selectors reset to code 1, reads give the stored value
// Notes: st bits 14 and 15 are the free levels
module ofs_output_function_select_tb;
  timeunit 1ns;
  timeprecision 1ps;
`define CK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
  $display("unexpected at %0t: %h vs %h", $time, a, b); end end
  logic        clk = 0, rstN = 0, pol = 0, wr = 0, rd = 0, stage = 0, ack, rej, o3, o4;
  logic [15:0] addr = 0, wd = 0, st = 0, rdata, act3 = 16'h1, act4 = 16'h1;
  logic [1:0]  seen;
  logic [15:0] codes [14] = '{16'h1, 16'h2, 16'h3, 16'h4, 16'h5, 16'h6, 16'h7, 16'h8,
                              16'h9, 16'hd, 16'he, 16'h10, 16'h16, 16'h17};
  logic [15:0] bad [4] = '{16'h0, 16'ha, 16'h11, 16'hffff};
  int          err_count = 0, total_checks = 0, cyc = 0;
  always #5 clk = ~clk;
  ofs_output_function_select dut (.ref_clk(clk), .arst_n(rstN), .powerOnLoad(pol),
    .paramWrite(wr), .paramRead(rd), .paramAddr(addr), .paramWdata(wd), .paramRdata(rdata),
    .paramAck(ack), .paramReject(rej), .powerStageEnabled(stage), .stReadyToSwitchOn(st[0]),
    .stSwitchedOn(st[1]), .stOperationEnabled(st[2]), .relativeMoveAfterCapture(st[3]),
    .posInWindow(st[4]), .velInWindow(st[5]), .velBelowThreshold(st[6]),
    .curBelowThreshold(st[7]), .haltAck(st[8]), .motorStandstill(st[9]),
    .selectedError(st[10]), .selectedWarning(st[11]), .movePositive(st[12]),
    .moveNegative(st[13]), .freeOut3(st[14]), .freeOut4(st[15]),
    .digitalOutputThree(o3), .digitalOutputFour(o4));
  ofs_load_model load (.clk(clk), .outThree(o3), .outFour(o4), .seen(seen));
  function automatic logic e(input [15:0] c, input [15:0] s, input f);
    case (c)
      16'h1: e = f;
      16'h2: e = |s[2:0];
      16'hd, 16'he: e = s[c - 4];
      16'h10: e = s[11];
      16'h16, 16'h17: e = s[c - 10];
      default: e = c > 2 && c < 10 ? s[c - 1] : 1'b0;
    endcase
  endfunction
  task acc(input w, input [15:0] a, input [15:0] d, input ok);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 0;
    rd <= 0;
    #1 `CK({ack, rej}, {ok, !ok})
  endtask
  task run(input int n);
    repeat (n) begin
      @(posedge clk);
      st <= 16'($urandom);
      @(posedge clk);
      #1 `CK({o3, o4}, {e(act3, st, st[14]), e(act4, st, st[15])})
      @(posedge clk);
      #1 `CK(seen, {e(act4, st, st[15]), e(act3, st, st[14])})
    end
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      tally_and_finish;
    end
  end
  initial begin
    void'($urandom(32'had39));
    repeat (12) @(posedge clk);
    rstN <= 1;
    repeat (3) @(posedge clk);
    stage <= 1;
    acc(1, 16'h0718, 16'h3, 0);
    stage <= 0;
    foreach (bad[i]) acc(1, 16'h071a, bad[i], 0);
    acc(0, 16'h071c, 16'h0, 0);
    `CK(rdata, 16'h0)
    acc(0, 16'h0718, 16'h0, 1);
    `CK(rdata, 16'h1)
    foreach (codes[i]) begin
      acc(1, 16'h0718, codes[i], 1);
      acc(1, 16'h071a, codes[13 - i], 1);
      run(2);
      @(posedge clk);
      pol <= 1;
      @(posedge clk);
      pol <= 0;
      act3 = codes[i];
      act4 = codes[13 - i];
      run(6);
    end
    acc(0, 16'h071a, 16'h0, 1);
    `CK(rdata, 16'h1)
    tally_and_finish;
  end
endmodule
